// [kbc_defines.vh]
// Function
// - Host write at 0x60 loads data, C/D=0
// - Host write at 0x64 loads command, C/D=1
// - Host reads status at 0x64, data at 0x60
// - Data write clears C/D, sets input full
// - Command write sets C/D, sets input full
// - Flag mode: host data read clears output full
// - CPU output write sets status bit 0
// - Status bit 3 follows host address bit 2
// - Flag mode: keyboard irq is gated output full
// - Keyboard irq low after reset
// - No flag mode: keyboard irq follows port bit
// - Flag mode: aux irq is gated inverted input full
// - No flag mode: aux irq follows port bit
// - Port bit 21 drives address 20 gate
// - Push mode: high pulse then release
// - Open-drain mode: zero low, one tristate
// - PS/2 bits inverted open-drain, read back
// - Halt enters soft power-down, host write exits
// - Wake by write calls irq if enabled
// - Stop enters hard power-down, oscillator off
// - CPU gets input-full and timer interrupts only
// - 2K program ROM, 256 byte data RAM
// - Status resets zero, CPU writes user bits
// - CPU input read clears input full
//
// Purpose: Constants of the keyboard controller host mailbox
// Assumes: 10 MHz controller clock
// Notes: Definitions only
`ifndef KBC_DEFINES_VH
`define KBC_DEFINES_VH
// ****************************************
// Host addresses
// ****************************************
`define HOST_DATA_PORT 8'h60
`define HOST_CMD_STATUS_PORT 8'h64
// ****************************************
// Status fields
// ****************************************
`define ST_OUT_FULL 0
`define ST_IN_FULL 1
`define ST_CMD_DATA 3
`define ST_USER_MASK 8'hf4
`define STATUS_RESET 8'h00
// ****************************************
// Port 2 bit positions, port 1 and port 2 reset values
// ****************************************
`define P2_A20 1
`define P2_MS_DAT 2
`define P2_MS_CLK 3
`define P2_KBD_IRQ 4
`define P2_AUX_IRQ 5
`define P2_KBD_CLK 6
`define P2_KBD_DAT 7
`define PORT2_RESET 8'hcc
`define PORT1_RESET 8'hff
// ****************************************
// Timing and memory
// ****************************************
`define CLK_PERIOD_NS 100
`define PUSH_HOLD_NS 500
`define PUSH_HOLD_CYC 4'h5
`define ROM_DEPTH 2048
`define RAM_DEPTH 256
`endif

// [kbc_host_mailbox.v]
// Purpose: Host mailbox, flags, irq pins and power modes of a keyboard controller
// Assumes: Host and CPU strobes are one-cycle pulses on ref_clk_i
// Notes: PS/2 pins are open-drain, enables active low
`timescale 1ns/1ps
`include "kbc_defines.vh"
module keyboard_ctrl_host_mailbox (
    input wire ref_clk_i,
    input wire srst_i,
    input wire [7:0] host_addr_i,
    input wire host_wr_i,
    input wire host_rd_i,
    input wire [7:0] host_wdata_i,
    output reg [7:0] host_rdata_o,
    input wire cpu_buffer_wr_i,
    input wire cpu_buffer_rd_i,
    input wire [7:0] cpu_wdata_i,
    output reg [7:0] cpu_input_buffer_o,
    output reg [7:0] cpu_status_o,
    input wire cpu_status_wr_i,
    input wire cpu_flags_en_i,
    input wire cpu_port1_wr_i,
    input wire cpu_port2_wr_i,
    input wire [7:0] pin_od_mode_i,
    input wire cpu_ibf_int_en_i,
    input wire cpu_tmr_int_en_i,
    input wire timer_ovf_i,
    input wire cpu_halt_i,
    input wire cpu_stop_i,
    input wire cpu_mem_wr_i,
    input wire cpu_rom_load_i,
    input wire [10:0] cpu_mem_addr_i,
    output reg [7:0] cpu_ram_rdata_o,
    output reg [7:0] cpu_rom_rdata_o,
    output reg cpu_ibf_irq_o,
    output reg cpu_timer_irq_o,
    output reg alu_clk_en_o,
    output reg osc_en_o,
    output reg wake_call_o,
    output reg restart_o,
    output reg keyboard_irq_out_o,
    output reg aux_irq_out_o,
    output wire addr20_gate_out_o,
    output wire addr20_gate_out_oe_n_o,
    output wire [2:0] port_pin_o,
    output wire [2:0] port_pin_oe_n_o,
    input wire ps2_kbd_clock_pin_i,
    input wire ps2_kbd_data_pin_i,
    input wire ps2_ms_clock_pin_i,
    input wire ps2_ms_data_pin_i,
    output reg ps2_kbd_clock_pin_o,
    output reg ps2_kbd_clock_pin_oe_n_o,
    output reg ps2_kbd_data_pin_o,
    output reg ps2_kbd_data_pin_oe_n_o,
    output reg ps2_ms_clock_pin_o,
    output reg ps2_ms_clock_pin_oe_n_o,
    output reg ps2_ms_data_pin_o,
    output reg ps2_ms_data_pin_oe_n_o,
    output reg kbd_clock_readback_o,
    output reg kbd_data_readback_o,
    output reg ms_clock_readback_o,
    output reg ms_data_readback_o
);
    localparam [2:0] ST_RUN = 3'b001;
    localparam [2:0] ST_SOFT = 3'b010;
    localparam [2:0] ST_HARD = 3'b100;

    reg [7:0] host_buffer;
    reg [7:0] out_buffer;
    reg [7:0] status;
    reg [7:0] port1;
    reg [7:0] port2;
    reg [2:0] pwr;
    reg [3:0] sync1;
    reg [3:0] sync2;
    reg rst_d;
    reg [7:0] ram [0:`RAM_DEPTH-1];
    reg [7:0] rom [0:`ROM_DEPTH-1];

    wire host_data_wr;
    wire host_cmd_wr;
    wire host_any_wr;
    wire host_data_rd;
    wire host_stat_rd;
    wire next_out_full;
    wire next_in_full;
    wire [7:0] next_port2;
    reg [7:0] next_status;

    // Port address compare
    function is_port;
        input [7:0] addr;
        input [7:0] port;
        begin
            is_port = (addr == port);
        end
    endfunction

    // ****************************************
    // Host address decode
    // ****************************************
    assign host_data_wr = host_wr_i && is_port(host_addr_i, `HOST_DATA_PORT);
    assign host_cmd_wr = host_wr_i && is_port(host_addr_i, `HOST_CMD_STATUS_PORT);
    assign host_any_wr = host_data_wr || host_cmd_wr;
    assign host_data_rd = host_rd_i && is_port(host_addr_i, `HOST_DATA_PORT);
    assign host_stat_rd = host_rd_i && is_port(host_addr_i, `HOST_CMD_STATUS_PORT);

    // ****************************************
    // Flag next values
    // ****************************************
    assign next_out_full = cpu_buffer_wr_i ? 1'b1 :
        (host_data_rd && cpu_flags_en_i) ? 1'b0 :
        status[`ST_OUT_FULL];
    assign next_in_full = host_any_wr ? 1'b1 :
        cpu_buffer_rd_i ? 1'b0 :
        status[`ST_IN_FULL];
    assign next_port2 = cpu_port2_wr_i ? cpu_wdata_i : port2;

    // ****************************************
    // Status next value
    // ****************************************
    always @* begin
        next_status = status;
        if (cpu_status_wr_i) begin
            next_status[7:4] = cpu_wdata_i[7:4];
            next_status[2] = cpu_wdata_i[2];
        end
        if (host_any_wr) begin
            next_status[`ST_CMD_DATA] = host_addr_i[2];
        end
        next_status[`ST_OUT_FULL] = next_out_full;
        next_status[`ST_IN_FULL] = next_in_full;
    end

    // ****************************************
    // Buffers and status
    // ****************************************
    always @(posedge ref_clk_i) begin
        if (srst_i) begin
            host_buffer <= 8'h00;
            out_buffer <= 8'h00;
            status <= `STATUS_RESET;
            host_rdata_o <= 8'h00;
            cpu_input_buffer_o <= 8'h00;
            cpu_status_o <= `STATUS_RESET;
        end else begin
            if (host_any_wr) begin
                host_buffer <= host_wdata_i;
            end
            if (cpu_buffer_wr_i) begin
                out_buffer <= cpu_wdata_i;
            end
            status <= next_status;
            if (host_stat_rd) begin
                host_rdata_o <= status;
            end else if (host_data_rd) begin
                host_rdata_o <= out_buffer;
            end
            if (cpu_buffer_rd_i) begin
                cpu_input_buffer_o <= host_buffer;
            end
            cpu_status_o <= next_status;
        end
    end

    // ****************************************
    // Port latches
    // ****************************************
    always @(posedge ref_clk_i) begin
        if (srst_i) begin
            port1 <= `PORT1_RESET;
            port2 <= `PORT2_RESET;
        end else begin
            if (cpu_port1_wr_i) begin
                port1 <= cpu_wdata_i;
            end
            port2 <= next_port2;
        end
    end

    // ****************************************
    // Host interrupt pins
    // ****************************************
    always @(posedge ref_clk_i) begin
        if (srst_i) begin
            keyboard_irq_out_o <= 1'b0;
            aux_irq_out_o <= 1'b0;
        end else if (cpu_flags_en_i) begin
            keyboard_irq_out_o <= next_port2[`P2_KBD_IRQ] & next_out_full;
            aux_irq_out_o <= next_port2[`P2_AUX_IRQ] & ~next_in_full;
        end else begin
            keyboard_irq_out_o <= next_port2[`P2_KBD_IRQ];
            aux_irq_out_o <= next_port2[`P2_AUX_IRQ];
        end
    end

    // ****************************************
    // Port pin drivers
    // ****************************************
    kbc_port_pin u_a20 (
        .ref_clk_i(ref_clk_i),
        .srst_i(srst_i),
        .bit_i(port2[`P2_A20]),
        .od_mode_i(pin_od_mode_i[3]),
        .pin_o(addr20_gate_out_o),
        .pin_oe_n_o(addr20_gate_out_oe_n_o)
    );
    kbc_port_pin u_p17 (
        .ref_clk_i(ref_clk_i),
        .srst_i(srst_i),
        .bit_i(port1[7]),
        .od_mode_i(pin_od_mode_i[2]),
        .pin_o(port_pin_o[2]),
        .pin_oe_n_o(port_pin_oe_n_o[2])
    );
    kbc_port_pin u_p16 (
        .ref_clk_i(ref_clk_i),
        .srst_i(srst_i),
        .bit_i(port1[6]),
        .od_mode_i(pin_od_mode_i[1]),
        .pin_o(port_pin_o[1]),
        .pin_oe_n_o(port_pin_oe_n_o[1])
    );
    kbc_port_pin u_p12 (
        .ref_clk_i(ref_clk_i),
        .srst_i(srst_i),
        .bit_i(port1[2]),
        .od_mode_i(pin_od_mode_i[0]),
        .pin_o(port_pin_o[0]),
        .pin_oe_n_o(port_pin_oe_n_o[0])
    );

    // ****************************************
    // PS/2 open-drain pins and readback
    // ****************************************
    always @(posedge ref_clk_i) begin
        if (srst_i) begin
            ps2_kbd_clock_pin_o <= 1'b0;
            ps2_kbd_data_pin_o <= 1'b0;
            ps2_ms_clock_pin_o <= 1'b0;
            ps2_ms_data_pin_o <= 1'b0;
            ps2_kbd_clock_pin_oe_n_o <= 1'b0;
            ps2_kbd_data_pin_oe_n_o <= 1'b0;
            ps2_ms_clock_pin_oe_n_o <= 1'b0;
            ps2_ms_data_pin_oe_n_o <= 1'b0;
            sync1 <= 4'h0;
            sync2 <= 4'h0;
            kbd_clock_readback_o <= 1'b0;
            kbd_data_readback_o <= 1'b0;
            ms_clock_readback_o <= 1'b0;
            ms_data_readback_o <= 1'b0;
        end else begin
            ps2_kbd_clock_pin_o <= 1'b0;
            ps2_kbd_data_pin_o <= 1'b0;
            ps2_ms_clock_pin_o <= 1'b0;
            ps2_ms_data_pin_o <= 1'b0;
            ps2_kbd_clock_pin_oe_n_o <= ~port2[`P2_KBD_CLK];
            ps2_kbd_data_pin_oe_n_o <= ~port2[`P2_KBD_DAT];
            ps2_ms_clock_pin_oe_n_o <= ~port2[`P2_MS_CLK];
            ps2_ms_data_pin_oe_n_o <= ~port2[`P2_MS_DAT];
            sync1 <= {ps2_kbd_clock_pin_i, ps2_kbd_data_pin_i,
                ps2_ms_clock_pin_i, ps2_ms_data_pin_i};
            sync2 <= sync1;
            kbd_clock_readback_o <= sync2[3];
            kbd_data_readback_o <= sync2[2];
            ms_clock_readback_o <= sync2[1];
            ms_data_readback_o <= sync2[0];
        end
    end

    // ****************************************
    // Power modes and CPU interrupts
    // ****************************************
    always @(posedge ref_clk_i) begin
        if (srst_i) begin
            pwr <= ST_RUN;
            alu_clk_en_o <= 1'b1;
            osc_en_o <= 1'b1;
            wake_call_o <= 1'b0;
            cpu_ibf_irq_o <= 1'b0;
            cpu_timer_irq_o <= 1'b0;
            rst_d <= 1'b1;
            restart_o <= 1'b0;
        end else begin
            wake_call_o <= 1'b0;
            rst_d <= 1'b0;
            restart_o <= rst_d;
            cpu_ibf_irq_o <= next_in_full & cpu_ibf_int_en_i;
            cpu_timer_irq_o <= timer_ovf_i & cpu_tmr_int_en_i;
            case (pwr)
                ST_RUN: begin
                    if (cpu_stop_i) begin
                        pwr <= ST_HARD;
                        alu_clk_en_o <= 1'b0;
                        osc_en_o <= 1'b0;
                    end else if (cpu_halt_i) begin
                        pwr <= ST_SOFT;
                        alu_clk_en_o <= 1'b0;
                    end
                end
                ST_SOFT: begin
                    if (host_any_wr) begin
                        pwr <= ST_RUN;
                        alu_clk_en_o <= 1'b1;
                        wake_call_o <= cpu_ibf_int_en_i;
                    end
                end
                ST_HARD: begin
                    if (host_any_wr) begin
                        pwr <= ST_RUN;
                        alu_clk_en_o <= 1'b1;
                        osc_en_o <= 1'b1;
                        wake_call_o <= cpu_ibf_int_en_i;
                    end
                end
                default: begin
                    pwr <= ST_RUN;
                    alu_clk_en_o <= 1'b1;
                    osc_en_o <= 1'b1;
                end
            endcase
        end
    end

    // ****************************************
    // Program ROM and data RAM
    // ****************************************
    always @(posedge ref_clk_i) begin
        if (cpu_mem_wr_i) begin
            ram[cpu_mem_addr_i[7:0]] <= cpu_wdata_i;
        end
        if (cpu_rom_load_i) begin
            rom[cpu_mem_addr_i] <= cpu_wdata_i;
        end
    end

    always @(posedge ref_clk_i) begin
        if (srst_i) begin
            cpu_ram_rdata_o <= 8'h00;
            cpu_rom_rdata_o <= 8'h00;
        end else begin
            cpu_ram_rdata_o <= ram[cpu_mem_addr_i[7:0]];
            cpu_rom_rdata_o <= rom[cpu_mem_addr_i];
        end
    end
endmodule // keyboard_ctrl_host_mailbox

// [kbc_host_model.sv]
// Purpose: System host model issuing byte cycles to the mailbox
// Assumes: One-cycle strobes, read data sampled the cycle after the take
// Notes: Released address and data show the inverse of the last value
`timescale 1ns/1ps
module kbc_host_model (
    input logic ref_clk_i,
    input logic [7:0] host_rdata_i,
    output logic [7:0] host_addr_o,
    output logic host_wr_o,
    output logic host_rd_o,
    output logic [7:0] host_wdata_o
);
    // ****************************************
    // Host cycles
    // ****************************************
    initial begin
        host_addr_o = 8'h00;
        host_wr_o = 1'b0;
        host_rd_o = 1'b0;
        host_wdata_o = 8'h00;
    end
    // Byte write to data or command port
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge ref_clk_i);
        host_addr_o <= a;
        host_wdata_o <= d;
        host_wr_o <= 1'b1;
        @(posedge ref_clk_i);
        host_wr_o <= 1'b0;
        host_addr_o <= ~a;
        host_wdata_o <= ~d;
    endtask
    // Byte read, answer taken one edge after the take
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(posedge ref_clk_i);
        host_addr_o <= a;
        host_rd_o <= 1'b1;
        @(posedge ref_clk_i);
        host_rd_o <= 1'b0;
        host_addr_o <= ~a;
        @(posedge ref_clk_i);
        d = host_rdata_i;
    endtask
endmodule // kbc_host_model

// [kbc_mailbox_chk.sv]
// Purpose: Port-level checks of the host mailbox
// Assumes: Single clock, synchronous reset
// Notes: Bound to the mailbox top
`timescale 1ns/1ps
module kbc_mailbox_chk (
    input logic ref_clk_i,
    input logic srst_i,
    input logic [7:0] host_addr_i,
    input logic host_wr_i,
    input logic host_rd_i,
    input logic [7:0] host_rdata_o,
    input logic cpu_buffer_wr_i,
    input logic cpu_buffer_rd_i,
    input logic cpu_flags_en_i,
    input logic cpu_halt_i,
    input logic cpu_stop_i,
    input logic [7:0] cpu_status_o,
    input logic alu_clk_en_o,
    input logic osc_en_o,
    input logic keyboard_irq_out_o,
    input logic aux_irq_out_o
);
    // ****************************************
    // Sequences and assertions
    // ****************************************
    default clocking @(posedge ref_clk_i); endclocking
    default disable iff (srst_i);
    sequence data_wr_s; host_wr_i && host_addr_i == 8'h60; endsequence
    sequence cmd_wr_s; host_wr_i && host_addr_i == 8'h64; endsequence
    sequence halted_wr_s; !alu_clk_en_o ##0 data_wr_s; endsequence
    data_write_a: assert property (data_wr_s |=> cpu_status_o[1] && !cpu_status_o[3])
        else $error("data write flags wrong");
    cmd_write_a: assert property (cmd_wr_s |=> cpu_status_o[1] && cpu_status_o[3])
        else $error("command write flags wrong");
    status_read_a: assert property (host_rd_i && host_addr_i == 8'h64
        |=> host_rdata_o == $past(cpu_status_o)) else $error("status read wrong");
    out_full_a: assert property (cpu_buffer_wr_i |=> cpu_status_o[0])
        else $error("output full not set");
    in_clear_a: assert property (cpu_buffer_rd_i && !host_wr_i |=> !cpu_status_o[1])
        else $error("input full not cleared");
    flag_read_a: assert property (cpu_flags_en_i && host_rd_i && host_addr_i == 8'h60
        && !cpu_buffer_wr_i |=> !cpu_status_o[0]) else $error("output full not cleared");
    kbd_gate_a: assert property (cpu_flags_en_i && $past(cpu_flags_en_i)
        && !cpu_status_o[0] && !$past(cpu_status_o[0]) |-> !keyboard_irq_out_o)
        else $error("keyboard irq without output full");
    aux_gate_a: assert property (cpu_flags_en_i && $past(cpu_flags_en_i)
        && cpu_status_o[1] && $past(cpu_status_o[1]) |-> !aux_irq_out_o)
        else $error("aux irq while input full");
    reset_clear_a: assert property ($fell(srst_i) |-> cpu_status_o == 8'h00
        && !keyboard_irq_out_o && !aux_irq_out_o) else $error("reset state wrong");
    soft_down_a: assert property (cpu_halt_i && !cpu_stop_i |=> !alu_clk_en_o && osc_en_o)
        else $error("halt did not stop alu");
    hard_down_a: assert property (cpu_stop_i |=> !osc_en_o)
        else $error("stop did not stop oscillator");
    host_wake_a: assert property (halted_wr_s |=> alu_clk_en_o)
        else $error("host write did not wake");
endmodule // kbc_mailbox_chk
bind keyboard_ctrl_host_mailbox kbc_mailbox_chk u_chk (.ref_clk_i(ref_clk_i),
    .srst_i(srst_i), .host_addr_i(host_addr_i), .host_wr_i(host_wr_i),
    .host_rd_i(host_rd_i), .host_rdata_o(host_rdata_o), .cpu_buffer_wr_i(cpu_buffer_wr_i),
    .cpu_buffer_rd_i(cpu_buffer_rd_i), .cpu_flags_en_i(cpu_flags_en_i),
    .cpu_halt_i(cpu_halt_i), .cpu_stop_i(cpu_stop_i), .cpu_status_o(cpu_status_o),
    .alu_clk_en_o(alu_clk_en_o), .osc_en_o(osc_en_o),
    .keyboard_irq_out_o(keyboard_irq_out_o), .aux_irq_out_o(aux_irq_out_o));

// [kbc_port_pin.v]
// Purpose: One controller port pin, push or open-drain drive
// Assumes: Output enable is active low
// Notes: Push mode drives high briefly then releases
`timescale 1ns/1ps
`include "kbc_defines.vh"
module kbc_port_pin (
    input wire ref_clk_i,
    input wire srst_i,
    input wire bit_i,
    input wire od_mode_i,
    output reg pin_o,
    output reg pin_oe_n_o
);
    localparam [3:0] HOLD = `PUSH_HOLD_CYC;
    reg [3:0] cnt;
    reg bit_d;
    // ****************************************
    // Drive logic
    // ****************************************
    always @(posedge ref_clk_i) begin
        if (srst_i) begin
            cnt <= 4'h0;
            bit_d <= 1'b1;
            pin_o <= 1'b0;
            pin_oe_n_o <= 1'b1;
        end else begin
            bit_d <= bit_i;
            pin_o <= 1'b0;
            if (!bit_i) begin
                cnt <= 4'h0;
                pin_oe_n_o <= 1'b0;
            end else if (od_mode_i) begin
                cnt <= 4'h0;
                pin_oe_n_o <= 1'b1;
            end else if (!bit_d) begin
                cnt <= HOLD;
                pin_o <= 1'b1;
                pin_oe_n_o <= 1'b0;
            end else if (cnt > 4'h1) begin
                cnt <= cnt - 4'h1;
                pin_o <= 1'b1;
                pin_oe_n_o <= 1'b0;
            end else begin
                cnt <= 4'h0;
                pin_oe_n_o <= 1'b1;
            end
        end
    end
endmodule // kbc_port_pin

// [keyboard_ctrl_host_mailbox_bench.sv]
// Purpose: Self-checking bench of the host mailbox
// Assumes: 10 MHz clock, PS/2 wires pulled up
// Notes: Host cycles come from the host model
`timescale 1ns/1ps
`include "kbc_defines.vh"
module keyboard_ctrl_host_mailbox_bench;
    logic ref_clk_i = 1'b0, srst_i = 1'b1;
    logic [7:0] host_addr_i, host_wdata_i, host_rdata_o, cpu_wdata_i, cpu_input_buffer_o;
    logic [7:0] cpu_status_o, pin_od_mode_i, cpu_ram_rdata_o, cpu_rom_rdata_o, v, a, d;
    logic host_wr_i, host_rd_i, cpu_buffer_wr_i, cpu_buffer_rd_i, cpu_status_wr_i, cd;
    logic cpu_flags_en_i, cpu_port1_wr_i, cpu_port2_wr_i, cpu_ibf_int_en_i, cpu_tmr_int_en_i;
    logic timer_ovf_i, cpu_halt_i, cpu_stop_i, cpu_mem_wr_i, cpu_rom_load_i;
    logic [10:0] cpu_mem_addr_i;
    logic cpu_ibf_irq_o, cpu_timer_irq_o, alu_clk_en_o, osc_en_o, wake_call_o, restart_o;
    logic keyboard_irq_out_o, aux_irq_out_o, addr20_gate_out_o, addr20_gate_out_oe_n_o;
    logic [2:0] port_pin_o, port_pin_oe_n_o;
    logic ps2_kbd_clock_pin_i, ps2_kbd_data_pin_i, ps2_ms_clock_pin_i, ps2_ms_data_pin_i;
    logic ps2_kbd_clock_pin_o, ps2_kbd_clock_pin_oe_n_o, ps2_kbd_data_pin_o;
    logic ps2_kbd_data_pin_oe_n_o, ps2_ms_clock_pin_o, ps2_ms_clock_pin_oe_n_o;
    logic ps2_ms_data_pin_o, ps2_ms_data_pin_oe_n_o, kbd_clock_readback_o;
    logic kbd_data_readback_o, ms_clock_readback_o, ms_data_readback_o;
    int error_cnt = 0, num_checks = 0, cnt;
    logic [16:0] rows [4] = '{{8'h60, 8'ha5, 1'b0}, {8'h64, 8'h3c, 1'b1},
        {8'h60, 8'h00, 1'b0}, {8'h64, 8'hff, 1'b1}};
    // ****************************************
    // Structure
    // ****************************************
    always #50 ref_clk_i = ~ref_clk_i;
    assign ps2_kbd_clock_pin_i = ps2_kbd_clock_pin_oe_n_o | ps2_kbd_clock_pin_o;
    assign ps2_kbd_data_pin_i = ps2_kbd_data_pin_oe_n_o | ps2_kbd_data_pin_o;
    assign ps2_ms_clock_pin_i = ps2_ms_clock_pin_oe_n_o | ps2_ms_clock_pin_o;
    assign ps2_ms_data_pin_i = ps2_ms_data_pin_oe_n_o | ps2_ms_data_pin_o;
    kbc_host_model host (.ref_clk_i(ref_clk_i), .host_rdata_i(host_rdata_o),
        .host_addr_o(host_addr_i), .host_wr_o(host_wr_i), .host_rd_o(host_rd_i),
        .host_wdata_o(host_wdata_i));
    keyboard_ctrl_host_mailbox DUT (.*);
    // ****************************************
    // Tasks
    // ****************************************
    task automatic tick(input int n);
        repeat (n) @(posedge ref_clk_i);
    endtask
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        num_checks++;
        if (got !== exp) begin
            error_cnt++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic cpu_pulse(input int k, input logic [7:0] dv);
        @(posedge ref_clk_i);
        cpu_wdata_i <= dv;
        case (k)
            0: cpu_buffer_rd_i <= 1'b1;
            1: cpu_buffer_wr_i <= 1'b1;
            2: cpu_port2_wr_i <= 1'b1;
            3: cpu_halt_i <= 1'b1;
            4: cpu_stop_i <= 1'b1;
            5: cpu_mem_wr_i <= 1'b1;
            7: cpu_port1_wr_i <= 1'b1;
            8: cpu_rom_load_i <= 1'b1;
            default: cpu_status_wr_i <= 1'b1;
        endcase
        @(posedge ref_clk_i);
        {cpu_buffer_rd_i, cpu_buffer_wr_i, cpu_port2_wr_i, cpu_halt_i} <= 4'h0;
        {cpu_stop_i, cpu_mem_wr_i, cpu_status_wr_i, cpu_port1_wr_i, cpu_rom_load_i} <= 5'h00;
    endtask
    task automatic do_reset();
        @(posedge ref_clk_i);
        srst_i <= 1'b1;
        tick(6);
        srst_i <= 1'b0;
        tick(2);
    endtask
    task automatic final_report();
        $display("checks %0d errors %0d", num_checks, error_cnt);
        if (error_cnt == 0 && num_checks > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask
    // ****************************************
    // Sequence
    // ****************************************
    initial begin
        {cpu_buffer_wr_i, cpu_buffer_rd_i, cpu_status_wr_i, cpu_flags_en_i} = 4'h0;
        {cpu_port1_wr_i, cpu_port2_wr_i, cpu_ibf_int_en_i, cpu_tmr_int_en_i} = 4'h0;
        {timer_ovf_i, cpu_halt_i, cpu_stop_i, cpu_mem_wr_i, cpu_rom_load_i} = 5'h00;
        cpu_wdata_i = 8'h00;
        pin_od_mode_i = 8'h00;
        cpu_mem_addr_i = 11'h000;
        do_reset();
        chk(restart_o, 8'h01);
        foreach (rows[i]) begin
            {a, d, cd} = rows[i];
            host.wr(a, d);
            host.rd(8'h64, v);
            chk(v & 8'h0a, {4'h0, cd, 3'h2});
            cpu_pulse(0, 8'h00);
            tick(1);
            chk(cpu_input_buffer_o, d);
            chk(cpu_status_o & 8'h02, 8'h00);
        end
        cpu_pulse(1, 8'h5a);
        host.rd(8'h60, v);
        chk(v, 8'h5a);
        chk(cpu_status_o & 8'h01, 8'h01);
        cpu_pulse(2, 8'h10);
        tick(2);
        chk({keyboard_irq_out_o, aux_irq_out_o}, 8'h02);
        cpu_pulse(2, 8'h20);
        tick(2);
        chk({keyboard_irq_out_o, aux_irq_out_o}, 8'h01);
        cpu_flags_en_i <= 1'b1;
        cpu_pulse(2, 8'h30);
        tick(2);
        chk({keyboard_irq_out_o, aux_irq_out_o}, 8'h03);
        host.wr(8'h60, 8'h11);
        host.rd(8'h60, v);
        tick(1);
        chk({keyboard_irq_out_o, aux_irq_out_o, cpu_status_o[0]}, 8'h00);
        cpu_pulse(2, 8'h00);
        cpu_pulse(1, 8'h22);
        tick(2);
        chk(keyboard_irq_out_o, 8'h00);
        cpu_pulse(0, 8'h00);
        cpu_flags_en_i <= 1'b0;
        cpu_pulse(2, 8'h02);
        cnt = 0;
        repeat (12) begin
            @(posedge ref_clk_i);
            if (!addr20_gate_out_oe_n_o && addr20_gate_out_o) cnt++;
        end
        chk(cnt, `PUSH_HOLD_CYC);
        chk(addr20_gate_out_oe_n_o, 8'h01);
        pin_od_mode_i <= 8'h08;
        cpu_pulse(2, 8'h00);
        tick(2);
        chk({addr20_gate_out_o, addr20_gate_out_oe_n_o}, 8'h00);
        cpu_pulse(2, 8'h02);
        tick(2);
        chk(addr20_gate_out_oe_n_o, 8'h01);
        cpu_pulse(7, 8'h00);
        tick(2);
        chk({port_pin_o, port_pin_oe_n_o}, 8'h00);
        cpu_pulse(2, 8'hc0);
        tick(5);
        chk({ps2_kbd_clock_pin_oe_n_o, ps2_kbd_data_pin_oe_n_o, ps2_ms_clock_pin_oe_n_o,
            ps2_ms_data_pin_oe_n_o, kbd_clock_readback_o, kbd_data_readback_o,
            ms_clock_readback_o, ms_data_readback_o}, 8'h33);
        cpu_pulse(2, 8'h0c);
        tick(5);
        chk({ps2_kbd_clock_pin_oe_n_o, ps2_kbd_data_pin_oe_n_o, ps2_ms_clock_pin_oe_n_o,
            ps2_ms_data_pin_oe_n_o, kbd_clock_readback_o, kbd_data_readback_o,
            ms_clock_readback_o, ms_data_readback_o}, 8'hcc);
        host.wr(8'h61, 8'h77);
        host.rd(8'h64, v);
        chk(v & 8'h02, 8'h00);
        cpu_ibf_int_en_i <= 1'b1;
        cpu_pulse(3, 8'h00);
        tick(1);
        chk({alu_clk_en_o, osc_en_o}, 8'h01);
        host.wr(8'h60, 8'haa);
        cnt = 0;
        repeat (3) begin
            @(posedge ref_clk_i);
            if (wake_call_o === 1'b1) cnt++;
        end
        chk(cnt, 8'h01);
        chk({alu_clk_en_o, cpu_ibf_irq_o}, 8'h03);
        cpu_tmr_int_en_i <= 1'b1;
        timer_ovf_i <= 1'b1;
        cpu_mem_addr_i <= 11'h0ff;
        cpu_pulse(5, 8'h3c);
        tick(2);
        chk({cpu_timer_irq_o}, 8'h01);
        chk(cpu_ram_rdata_o, 8'h3c);
        cpu_pulse(8, 8'h5c);
        tick(2);
        chk(cpu_rom_rdata_o, 8'h5c);
        cpu_pulse(6, 8'hff);
        tick(1);
        chk(cpu_status_o & 8'hf4, 8'hf4);
        cpu_pulse(4, 8'h00);
        tick(1);
        chk(osc_en_o, 8'h00);
        do_reset();
        chk({restart_o, port_pin_oe_n_o}, 8'h0f);
        host.rd(8'h64, v);
        chk(v, `STATUS_RESET);
        chk({osc_en_o, keyboard_irq_out_o, aux_irq_out_o}, 8'h04);
        chk({ps2_kbd_clock_pin_oe_n_o, ps2_ms_data_pin_oe_n_o, ps2_kbd_data_pin_o}, 8'h00);
        final_report();
    end
endmodule // keyboard_ctrl_host_mailbox_bench
